// [uhp_pkg.sv]
// constants of the dual-channel host port and modem pin block
// How it works
// - host addresses a channel by holding its select low; only that channel transfers.
// - low clear-to-send means modem accepts data; shown in modem status bit 4.
// - modem pins never touch serial transmit or receive; status and control only.
// - low data-set-ready means modem powered and ready to exchange data.
// - writing one to modem control bit 0 drives terminal-ready low.
// - writing zero to modem control bit 0, or any reset, drives terminal-ready high.
// - eight-bit two-way data bus, undriven unless read data is driven.
// - bus line zero is the byte's least significant and first serial bit.
// - interrupt output enabled by modem control bit 3 alone; asserted only with bit 3 and an enabled pending source.
// - enabled interrupt asserts on receive error, data, transmit empty or modem change and holds until a write clears the status bit.
// - each channel has its own interrupt output, able to float.
// - falling read strobe puts addressed register on the data bus.
// - falling write strobe captures the data bus into the addressed register.
// - modem control bit 3 zero floats interrupt, user output two high; one the reverse.
// - three address lines pick the register of the selected channel.
// - reset high clears the channel registers, drives the active-low outputs high and the interrupts low.
package uhp_pkg;
  localparam int NCH = 2;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_ISR = 3'h2;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  localparam int MCR_DTR = 0;
  localparam int MCR_OUT2 = 3;
  localparam int MSR_DCTS = 0;
  localparam int MSR_DDSR = 1;
  localparam int MSR_CTS = 4;
  localparam int MSR_DSR = 5;
  localparam int EV_RXERR = 0;
  localparam int EV_RXAV = 1;
  localparam int EV_TXE = 2;
  localparam int EV_MDM = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_EV = 4'h0;
endpackage

// [uhp_port.sv]
// host parallel port, modem pins and interrupt logic of two channels
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module uhp_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic reg_select_bit_zero,
  input wire logic reg_select_bit_one,
  input wire logic reg_select_bit_two,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  input wire logic clear_to_send_a_n,
  input wire logic clear_to_send_b_n,
  input wire logic data_set_ready_a_n,
  input wire logic data_set_ready_b_n,
  output logic terminal_ready_a_n,
  output logic terminal_ready_b_n,
  output logic irq_out_a,
  output logic irq_out_b,
  output logic irq_oe_a_n,
  output logic irq_oe_b_n,
  output logic user_output_two_a_n,
  output logic user_output_two_b_n,
  input wire logic rx_error_evt_a,
  input wire logic rx_error_evt_b,
  input wire logic rx_avail_evt_a,
  input wire logic rx_avail_evt_b,
  input wire logic tx_empty_evt_a,
  input wire logic tx_empty_evt_b
);
  localparam int SW = 19;

  // pins arrive from another domain: two flops, then a third for edges
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [SW-1:0] prev_reg;

  assign pin_raw = {channel_a_select_n, channel_b_select_n, host_read_strobe_n,
    host_write_strobe_n, reg_select_bit_two, reg_select_bit_one, reg_select_bit_zero,
    host_data_in, clear_to_send_a_n, clear_to_send_b_n, data_set_ready_a_n,
    data_set_ready_b_n};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= {SW{1'b1}};
      sync2_reg <= {SW{1'b1}};
      prev_reg <= {SW{1'b1}};
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic [1:0] sel;
  logic rd_n;
  logic wr_n;
  logic rd_fall;
  logic wr_fall;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [1:0] cts_n;
  logic [1:0] dsr_n;
  logic [1:0] cts_chg;
  logic [1:0] dsr_chg;

  always_comb begin
    sel = ~{sync2_reg[17], sync2_reg[18]};
    rd_n = sync2_reg[16];
    wr_n = sync2_reg[15];
    rd_fall = prev_reg[16] & ~sync2_reg[16];
    wr_fall = prev_reg[15] & ~sync2_reg[15];
    addr = sync2_reg[14:12];
    wdata = sync2_reg[11:4];
    cts_n = {sync2_reg[2], sync2_reg[3]};
    dsr_n = {sync2_reg[0], sync2_reg[1]};
    cts_chg = cts_n ^ {prev_reg[2], prev_reg[3]};
    dsr_chg = dsr_n ^ {prev_reg[0], prev_reg[1]};
  end

  logic [2:0] ev_in [uhp_pkg::NCH];
  assign ev_in[0] = {tx_empty_evt_a, rx_avail_evt_a, rx_error_evt_a};
  assign ev_in[1] = {tx_empty_evt_b, rx_avail_evt_b, rx_error_evt_b};

  // per-channel registers, then the shared read data and bus enable
  logic [3:0] ier_reg [uhp_pkg::NCH];
  logic [3:0] ier_next [uhp_pkg::NCH];
  logic [3:0] isr_reg [uhp_pkg::NCH];
  logic [3:0] isr_next [uhp_pkg::NCH];
  logic [7:0] mcr_reg [uhp_pkg::NCH];
  logic [7:0] mcr_next [uhp_pkg::NCH];
  logic [7:0] scr_reg [uhp_pkg::NCH];
  logic [7:0] scr_next [uhp_pkg::NCH];
  logic [1:0] dlt_reg [uhp_pkg::NCH];
  logic [1:0] dlt_next [uhp_pkg::NCH];
  logic [1:0] dtr_n_reg;
  logic [1:0] dtr_n_next;
  logic [1:0] irq_reg;
  logic [1:0] irq_next;
  logic [1:0] irq_oe_n_reg;
  logic [1:0] irq_oe_n_next;
  logic [1:0] op2_n_reg;
  logic [1:0] op2_n_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic oe_n_reg;
  logic oe_n_next;

  // register read decode, used for both channels
  function automatic logic [7:0] reg_read(input logic [2:0] a, input logic [3:0] irq_enable_reg,
      input logic [3:0] isr, input logic [7:0] modem_control_reg, input logic [7:0] scr,
      input logic [1:0] dlt, input logic cts_pin_n, input logic dsr_pin_n);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      uhp_pkg::OFS_IER: r = {4'h0, irq_enable_reg};
      uhp_pkg::OFS_ISR: r = {4'h0, isr};
      uhp_pkg::OFS_MCR: r = modem_control_reg;
      uhp_pkg::OFS_MSR: begin
        r[uhp_pkg::MSR_CTS] = ~cts_pin_n;
        r[uhp_pkg::MSR_DSR] = ~dsr_pin_n;
        r[uhp_pkg::MSR_DCTS] = dlt[0];
        r[uhp_pkg::MSR_DDSR] = dlt[1];
      end
      uhp_pkg::OFS_SCR: r = scr;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  always_comb begin
    logic [1:0] wr_ch;
    logic [1:0] rd_ch;
    logic [3:0] ev;
    ev = 4'h0;
    wr_ch = sel & {2{wr_fall}};
    rd_ch = sel & {2{rd_fall}};
    for (int c = 0; c < uhp_pkg::NCH; c++) begin
      ier_next[c] = ier_reg[c];
      mcr_next[c] = mcr_reg[c];
      scr_next[c] = scr_reg[c];
      dlt_next[c] = dlt_reg[c] | {dsr_chg[c], cts_chg[c]};
      ev = {cts_chg[c] | dsr_chg[c], ev_in[c]};
      isr_next[c] = isr_reg[c];
      if (wr_ch[c]) begin
        case (addr)
          uhp_pkg::OFS_IER: ier_next[c] = wdata[3:0];
          uhp_pkg::OFS_ISR: isr_next[c] = isr_reg[c] & ~wdata[3:0];
          uhp_pkg::OFS_MCR: mcr_next[c] = wdata;
          uhp_pkg::OFS_SCR: scr_next[c] = wdata;
          default: ;
        endcase
      end
      // an event in the clearing cycle survives the clear
      isr_next[c] = isr_next[c] | ev;
      // reading modem status hands the change flags back to software
      if (rd_ch[c] && addr == uhp_pkg::OFS_MSR) begin
        dlt_next[c] = {dsr_chg[c], cts_chg[c]};
      end
      dtr_n_next[c] = ~mcr_next[c][uhp_pkg::MCR_DTR];
      // pins reach status and, through the modem change event, the interrupt; no serial path reads them
      irq_next[c] = mcr_next[c][uhp_pkg::MCR_OUT2] & (|(isr_next[c] & ier_next[c]));
      irq_oe_n_next[c] = ~mcr_next[c][uhp_pkg::MCR_OUT2];
      op2_n_next[c] = ~mcr_next[c][uhp_pkg::MCR_OUT2];
    end
    rdata_next = rdata_reg;
    // channel a wins if the host selects both at once
    if (rd_ch[0]) begin
      rdata_next = reg_read(addr, ier_reg[0], isr_reg[0], mcr_reg[0], scr_reg[0],
        dlt_reg[0], cts_n[0], dsr_n[0]);
    end else if (rd_ch[1]) begin
      rdata_next = reg_read(addr, ier_reg[1], isr_reg[1], mcr_reg[1], scr_reg[1],
        dlt_reg[1], cts_n[1], dsr_n[1]);
    end
    // drive only while the strobe of a selected channel is held low
    oe_n_next = ~(~rd_n & ~prev_reg[16] & (|sel));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int c = 0; c < uhp_pkg::NCH; c++) begin
        ier_reg[c] <= uhp_pkg::RST_EV;
        isr_reg[c] <= uhp_pkg::RST_EV;
        mcr_reg[c] <= uhp_pkg::RST_BYTE;
        scr_reg[c] <= uhp_pkg::RST_BYTE;
        dlt_reg[c] <= 2'h0;
      end
      dtr_n_reg <= 2'h3;
      irq_reg <= 2'h0;
      irq_oe_n_reg <= 2'h3;
      op2_n_reg <= 2'h3;
      rdata_reg <= uhp_pkg::RST_BYTE;
      oe_n_reg <= 1'b1;
    end else begin
      for (int c = 0; c < uhp_pkg::NCH; c++) begin
        ier_reg[c] <= ier_next[c];
        isr_reg[c] <= isr_next[c];
        mcr_reg[c] <= mcr_next[c];
        scr_reg[c] <= scr_next[c];
        dlt_reg[c] <= dlt_next[c];
      end
      dtr_n_reg <= dtr_n_next;
      irq_reg <= irq_next;
      irq_oe_n_reg <= irq_oe_n_next;
      op2_n_reg <= op2_n_next;
      rdata_reg <= rdata_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign host_data_out = rdata_reg;
  assign host_data_oe_n = oe_n_reg;
  assign terminal_ready_a_n = dtr_n_reg[0];
  assign terminal_ready_b_n = dtr_n_reg[1];
  assign irq_out_a = irq_reg[0];
  assign irq_out_b = irq_reg[1];
  assign irq_oe_a_n = irq_oe_n_reg[0];
  assign irq_oe_b_n = irq_oe_n_reg[1];
  assign user_output_two_a_n = op2_n_reg[0];
  assign user_output_two_b_n = op2_n_reg[1];
endmodule

// [uhp_modem.sv]
// modem model facing one channel's modem pins
`timescale 1ns/1ps
module uhp_modem (
  input wire logic clk,
  input wire logic powered,
  input wire logic terminal_ready_n,
  output logic clear_to_send_n,
  output logic data_set_ready_n
);
  // a modem only offers to take data once the terminal says it is ready
  always_ff @(posedge clk) begin
    data_set_ready_n <= !powered;
    clear_to_send_n <= terminal_ready_n | !powered;
  end
endmodule

// [uhp_port_monitor.sv]
// checker of the host port and modem pins
`timescale 1ns/1ps
module uhp_port_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic reg_select_bit_zero,
  input wire logic reg_select_bit_one,
  input wire logic reg_select_bit_two,
  input wire logic [7:0] host_data_in,
  input wire logic host_data_oe_n,
  input wire logic terminal_ready_a_n,
  input wire logic terminal_ready_b_n,
  input wire logic irq_out_a,
  input wire logic irq_out_b,
  input wire logic irq_oe_a_n,
  input wire logic irq_oe_b_n,
  input wire logic user_output_two_a_n,
  input wire logic user_output_two_b_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reset_outputs_a: assert property ($fell(sys_rst) |-> terminal_ready_a_n && terminal_ready_b_n && host_data_oe_n)
    else $error("outputs not idle after reset");
  a_pins_pair_a: assert property (user_output_two_a_n == irq_oe_a_n)
    else $error("channel a output two and irq enable differ");
  b_pins_pair_a: assert property (user_output_two_b_n == irq_oe_b_n)
    else $error("channel b output two and irq enable differ");
  a_irq_float_a: assert property (irq_oe_a_n |-> !irq_out_a)
    else $error("channel a irq active while floating");
  b_irq_float_a: assert property (irq_oe_b_n |-> !irq_out_b)
    else $error("channel b irq active while floating");
  bus_release_a: assert property (host_read_strobe_n[*5] |-> host_data_oe_n)
    else $error("bus driven without read");
  deselect_quiet_a: assert property ((channel_a_select_n && channel_b_select_n)[*5] |-> host_data_oe_n)
    else $error("bus driven while deselected");
  read_drive_a: assert property (($fell(host_read_strobe_n) && !channel_a_select_n) ##1
    (!host_read_strobe_n && !channel_a_select_n)[*3] |=> !host_data_oe_n) else $error("read not driven");
  dtr_write_a: assert property (($fell(host_write_strobe_n) && !channel_a_select_n &&
    {reg_select_bit_two, reg_select_bit_one, reg_select_bit_zero} == 3'h4) ##1
    (!host_write_strobe_n && $stable(host_data_in))[*3] |-> terminal_ready_a_n == !host_data_in[0])
    else $error("terminal ready wrong after write");
endmodule
bind uhp_port uhp_port_monitor mon (.*);

// [test_uhp_port.sv]
// testbench of the host port and modem pin block
`timescale 1ns/1ps
module test_uhp_port;
  logic clk = 0, sys_rst = 1, pwr = 0, channel_a_select_n = 1, channel_b_select_n = 1;
  logic host_read_strobe_n = 1, host_write_strobe_n = 1, reg_select_bit_zero = 0, reg_select_bit_one = 0;
  logic reg_select_bit_two = 0, rx_error_evt_a = 0, rx_error_evt_b = 0, rx_avail_evt_a = 0, rx_avail_evt_b = 0;
  logic tx_empty_evt_a = 0, tx_empty_evt_b = 0;
  logic [7:0] cpu = 8'h00, rdv, host_data_in, host_data_out;
  logic host_data_oe_n, terminal_ready_a_n, terminal_ready_b_n, irq_out_a, irq_out_b, irq_oe_a_n, irq_oe_b_n;
  logic user_output_two_a_n, user_output_two_b_n, clear_to_send_a_n, clear_to_send_b_n;
  logic data_set_ready_a_n, data_set_ready_b_n;
  int miscompares = 0, tests_run = 0, cyc = 0;
  always #2.5 clk = ~clk;
  // an undriven bus shows the inverse of the last byte, never a friendly value
  assign host_data_in = !host_data_oe_n ? host_data_out : (!host_write_strobe_n ? cpu : ~cpu);
  uhp_port dut (.*);
  uhp_modem ma (.clk(clk), .powered(pwr), .terminal_ready_n(terminal_ready_a_n),
    .clear_to_send_n(clear_to_send_a_n), .data_set_ready_n(data_set_ready_a_n));
  uhp_modem mb (.clk(clk), .powered(pwr), .terminal_ready_n(terminal_ready_b_n),
    .clear_to_send_n(clear_to_send_b_n), .data_set_ready_n(data_set_ready_b_n));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // strobes held four clocks low and high: synchronisers need three
  task automatic acc(input logic w, input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {channel_b_select_n, channel_a_select_n} <= s;
    {reg_select_bit_two, reg_select_bit_one, reg_select_bit_zero} <= a;
    cpu <= d;
    host_write_strobe_n <= !w;
    host_read_strobe_n <= w;
    repeat (4) @(posedge clk);
    host_write_strobe_n <= 1;
    host_read_strobe_n <= 1;
    repeat (4) @(posedge clk);
    {channel_b_select_n, channel_a_select_n} <= 2'h3;
    rdv = host_data_out;
  endtask
  task automatic t_dtr;
    acc(1, 2'h2, 3'h4, 8'h01);
    chk("dtr", {6'h00, terminal_ready_b_n, terminal_ready_a_n}, 8'h02);
    acc(1, 2'h2, 3'h4, 8'h00);
    chk("dtr", {6'h00, terminal_ready_b_n, terminal_ready_a_n}, 8'h03);
    acc(1, 2'h1, 3'h4, 8'h08);
    chk("op2", {5'h00, user_output_two_b_n, irq_oe_b_n, user_output_two_a_n}, 8'h01);
  endtask
  task automatic t_msr;
    // the modem only grants clear-to-send once terminal-ready is asserted
    acc(1, 2'h2, 3'h4, 8'h01);
    pwr <= 1;
    acc(0, 2'h2, 3'h6, 8'h00);
    chk("msr", rdv & 8'h30, 8'h30);
    pwr <= 0;
    acc(0, 2'h2, 3'h6, 8'h00);
    chk("msr", rdv & 8'h30, 8'h00);
  endtask
  task automatic t_scr;
    acc(1, 2'h2, 3'h7, 8'h81);
    acc(0, 2'h2, 3'h7, 8'h00);
    chk("scr", rdv, 8'h81);
    acc(1, 2'h3, 3'h7, 8'h3C);
    acc(0, 2'h2, 3'h7, 8'h00);
    chk("scr", rdv, 8'h81);
    acc(0, 2'h1, 3'h7, 8'h00);
    chk("scr_b", rdv, 8'h00);
  endtask
  task automatic t_irq;
    acc(1, 2'h2, 3'h4, 8'h08);
    acc(1, 2'h2, 3'h1, 8'h02);
    rx_avail_evt_a <= 1;
    @(posedge clk);
    rx_avail_evt_a <= 0;
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, irq_out_a}, 8'h01);
    acc(1, 2'h2, 3'h2, 8'h02);
    chk("irq", {7'h00, irq_out_a}, 8'h00);
  endtask
  task automatic give_verdict;
    $display("tests %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      give_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    chk("rst", {terminal_ready_b_n, terminal_ready_a_n, irq_oe_a_n, host_data_oe_n}, 8'h0F);
    t_dtr;
    t_msr;
    t_scr;
    t_irq;
    give_verdict;
  end
endmodule
